/* hw/ledseq_cfg.svh */
// Timing and width constants for the LED driver start-up sequencer
`ifndef LEDSEQ_CFG_SVH
`define LEDSEQ_CFG_SVH
`define LEDSEQ_CLK_HZ 100000000
`define LEDSEQ_RESET_US 256
`define LEDSEQ_SS_MS 128
`define LEDSEQ_BLANK_MS 256
`define LEDSEQ_SHDN_MS 32
`define LEDSEQ_RESET_CYC ((`LEDSEQ_RESET_US * (`LEDSEQ_CLK_HZ / 1000000)))
`define LEDSEQ_SS_CYC ((`LEDSEQ_SS_MS * (`LEDSEQ_CLK_HZ / 1000)))
`define LEDSEQ_BLANK_CYC ((`LEDSEQ_BLANK_MS * (`LEDSEQ_CLK_HZ / 1000)))
`define LEDSEQ_SHDN_CYC ((`LEDSEQ_SHDN_MS * (`LEDSEQ_CLK_HZ / 1000)))
`define LEDSEQ_CNT_W 32
`define LEDSEQ_NCH 4
`endif

/* hw/ledseq_pkg.sv */
// Types for the LED driver start-up sequencer
package ledseq_pkg;
   typedef enum logic [5:0] {
      LEDSEQ_OFF   = 6'h01,
      LEDSEQ_CHECK = 6'h02,
      LEDSEQ_SOFT  = 6'h04,
      LEDSEQ_BLANK = 6'h08,
      LEDSEQ_RUN   = 6'h10,
      LEDSEQ_FAULT = 6'h20
   } ledseq_state_t;
endpackage

/* hw/ledseq_top.sv */
// Start-up, channel check, soft-start, blanking and protection sequencer
//
// Summary of operation
// - Start-up begins only with the enable input high and the supply above lockout.
// - Right after start-up a 256 us window checks which of the four channels are connected.
// - In that window a sense input below 0.4 V marks the channel used, above marks it unused.
// - After the check every unused channel keeps its gate drive off for good.
// - After the check soft-start holds the feedback output at its fixed 3.3 V level for 128 ms.
// - After soft-start the feedback output is released to headroom regulation.
// - Protection stays off until a 256 ms blanking period after soft-start has passed.
// - With protection armed an open or shorted string switches the channel drivers off.
// - A protection event turns on the open-drain fault pull-down; the outside adds a pull-up.
// - Open and short protection are off through soft-start and until blanking ends.
`timescale 1ns/1ps
`default_nettype none
`include "ledseq_cfg.svh"
module ledseq_top #(
   parameter int NCH = `LEDSEQ_NCH,
   parameter int RESET_CYC = `LEDSEQ_RESET_CYC,
   parameter int SS_CYC = `LEDSEQ_SS_CYC,
   parameter int BLANK_CYC = `LEDSEQ_BLANK_CYC,
   parameter int SHDN_CYC = `LEDSEQ_SHDN_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Enable and supply
   input wire logic enable_dim,
   input wire logic supply_ok,
   // Channel sense comparators, high when sense is below 0.4 V
   input wire logic [NCH-1:0] sense_below_ref,
   // Protection detectors
   input wire logic [NCH-1:0] open_string_protection,
   input wire logic short_string_protection,
   // Channel gate enables
   output logic [NCH-1:0] channel_gate_drive,
   // Feedback control: high holds the fixed 3.3 V level
   output logic fb_hold_fixed,
   output logic fb_regulate,
   // Open-drain fault pin
   output logic fault_oe,
   output logic fault_out,
   // Status
   output logic [NCH-1:0] channel_used,
   output logic active
);
   import ledseq_pkg::*;

   // Elaboration check of parameters
   if (NCH < 1 || RESET_CYC < 1 || SS_CYC < 1 || BLANK_CYC < 1 || SHDN_CYC < 1) begin : g_chk
      $error("ledseq_top: counts and channel number must be positive");
   end

   ledseq_state_t state_q;
   ledseq_state_t state_d;
   logic [`LEDSEQ_CNT_W-1:0] tmr_q;
   logic [`LEDSEQ_CNT_W-1:0] shdn_q;
   logic [NCH-1:0] used_q;
   logic fault_ev;
   logic tmr_done;
   logic shdn_done;
   logic powered;

   // Phase timer end and shutdown end
   assign tmr_done = (state_q == LEDSEQ_CHECK) ? (tmr_q == `LEDSEQ_CNT_W'(RESET_CYC - 1)) :
                     (state_q == LEDSEQ_SOFT) ? (tmr_q == `LEDSEQ_CNT_W'(SS_CYC - 1)) :
                     (tmr_q == `LEDSEQ_CNT_W'(BLANK_CYC - 1));
   assign shdn_done = !enable_dim && (shdn_q == `LEDSEQ_CNT_W'(SHDN_CYC - 1));
   assign powered = (state_q != LEDSEQ_OFF);
   assign fault_ev = (|(open_string_protection & used_q)) || short_string_protection;

   // Next-state logic
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LEDSEQ_OFF: begin
            if (enable_dim && supply_ok) begin
               state_d = LEDSEQ_CHECK;
            end
         end
         LEDSEQ_CHECK: begin
            if (tmr_done) begin
               state_d = LEDSEQ_SOFT;
            end
         end
         LEDSEQ_SOFT: begin
            if (tmr_done) begin
               state_d = LEDSEQ_BLANK;
            end
         end
         LEDSEQ_BLANK: begin
            if (tmr_done) begin
               state_d = LEDSEQ_RUN;
            end
         end
         LEDSEQ_RUN: begin
            if (fault_ev) begin
               state_d = LEDSEQ_FAULT;
            end
         end
         LEDSEQ_FAULT: begin
            state_d = LEDSEQ_FAULT;
         end
      endcase
      // Shutdown after delay or on lockout
      if (powered && (shdn_done || !supply_ok)) begin
         state_d = LEDSEQ_OFF;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= LEDSEQ_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Phase timer, cleared on every phase change
   always_ff @(posedge sys_clk) begin
      if (!rst_b || state_d != state_q) begin
         tmr_q <= '0;
      end else if (state_q inside {LEDSEQ_CHECK, LEDSEQ_SOFT, LEDSEQ_BLANK}) begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   // Shutdown delay counter, low pulses shorter than SHDN_CYC cycles do not restart phases
   always_ff @(posedge sys_clk) begin
      if (!rst_b || enable_dim || !powered) begin
         shdn_q <= '0;
      end else if (!shdn_done) begin
         shdn_q <= shdn_q + 1'b1;
      end
   end

   // Channel classification during the check window
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         used_q <= '0;
      end else if (state_q == LEDSEQ_CHECK) begin
         used_q <= sense_below_ref;
      end
   end

   // Gate drive, feedback and status outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         channel_gate_drive <= '0;
         fb_hold_fixed <= 1'b0;
         fb_regulate <= 1'b0;
         channel_used <= '0;
         active <= 1'b0;
      end else begin
         // Unused channels stay off; gated by enable
         channel_gate_drive <= (state_d inside {LEDSEQ_SOFT, LEDSEQ_BLANK, LEDSEQ_RUN} &&
                                enable_dim) ? used_q : '0;
         fb_hold_fixed <= (state_d == LEDSEQ_CHECK) || (state_d == LEDSEQ_SOFT);
         fb_regulate <= state_d inside {LEDSEQ_BLANK, LEDSEQ_RUN, LEDSEQ_FAULT};
         channel_used <= used_q;
         active <= (state_d != LEDSEQ_OFF);
      end
   end

   // Open-drain fault pull-down, held until shutdown
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         fault_oe <= 1'b0;
         fault_out <= 1'b0;
      end else begin
         fault_oe <= (state_d == LEDSEQ_FAULT);
         fault_out <= 1'b0;
      end
   end

   // Assertion sequences
   sequence s_enter_run;
      state_q == LEDSEQ_BLANK ##1 state_q == LEDSEQ_RUN;
   endsequence

   a_start_qualify: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_OFF && state_d == LEDSEQ_CHECK |-> enable_dim && supply_ok)
      else $error("start without enable and supply");
   a_check_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(state_q == LEDSEQ_CHECK) |-> state_q == LEDSEQ_CHECK && tmr_q == '0)
      else $error("check window not started at zero");
   a_check_exit: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_CHECK && state_d == LEDSEQ_SOFT
      |-> tmr_q == `LEDSEQ_CNT_W'(RESET_CYC - 1))
      else $error("check window length wrong");
   a_unused_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (channel_gate_drive & ~channel_used) == '0)
      else $error("unused channel driven");
   a_ss_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_SOFT |-> fb_hold_fixed && !fb_regulate)
      else $error("feedback not fixed in soft-start");
   a_fb_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_BLANK |-> !fb_hold_fixed && fb_regulate)
      else $error("feedback not released");
   a_blank_arm: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q inside {LEDSEQ_SOFT, LEDSEQ_BLANK} |=> state_q != LEDSEQ_FAULT)
      else $error("fault during blanking");
   a_run_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_enter_run |-> $past(tmr_q) == `LEDSEQ_CNT_W'(BLANK_CYC - 1))
      else $error("armed before blanking end");
   a_fault_trip: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_RUN && fault_ev && enable_dim && supply_ok |=>
      channel_gate_drive == '0 && fault_oe)
      else $error("fault did not trip");
   a_shdn_delay: assert property (@(posedge sys_clk) disable iff (!rst_b)
      powered && supply_ok && state_d == LEDSEQ_OFF |-> shdn_q == `LEDSEQ_CNT_W'(SHDN_CYC - 1))
      else $error("shutdown before delay");
   a_dim_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_q == LEDSEQ_RUN && !enable_dim && !shdn_done && supply_ok && !fault_ev
      |=> state_q == LEDSEQ_RUN)
      else $error("dimming restarted sequence");
endmodule
`default_nettype wire

/* testbench/ledseq_led_model.sv */
// Partner model: LED strings, sense resistors and fault pull-up
`timescale 1ns/1ps
`default_nettype none
module ledseq_led_model (
   // Scenario controls
   input wire logic [3:0] fitted,
   input wire logic [3:0] broken,
   input wire logic shorted,
   // Device pins
   input wire logic [3:0] channel_gate_drive,
   input wire logic fault_oe,
   input wire logic fault_out,
   output logic [3:0] sense_below_ref,
   output logic [3:0] open_string_protection,
   output logic short_string_protection,
   output logic fault_line
);
   // Fitted strings pull sense low, empty channels float high
   assign sense_below_ref = fitted;
   // Broken string shows open only while driven
   assign open_string_protection = broken & fitted & channel_gate_drive;
   assign short_string_protection = shorted;
   assign fault_line = fault_oe ? fault_out : 1'b1;
endmodule
`default_nettype wire

/* testbench/tb_ledseq_top.sv */
// Self-checking bench for the LED start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_ledseq_top;
   localparam int RC = 8, SC = 20, BC = 30, DC = 10;
   logic sys_clk, rst_b, enable_dim, supply_ok, shorted, fault_oe, fault_out, fault_line;
   logic fb_hold_fixed, fb_regulate, active, short_string_protection;
   logic [3:0] fitted, broken, sense_below_ref, open_string_protection, channel_gate_drive;
   logic [3:0] channel_used;
   int miscompares = 0, cmp_count = 0, cyc = 0, n;
   ledseq_top #(.RESET_CYC(RC), .SS_CYC(SC), .BLANK_CYC(BC), .SHDN_CYC(DC)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .enable_dim(enable_dim), .supply_ok(supply_ok),
      .sense_below_ref(sense_below_ref), .open_string_protection(open_string_protection),
      .short_string_protection(short_string_protection),
      .channel_gate_drive(channel_gate_drive), .fb_hold_fixed(fb_hold_fixed),
      .fb_regulate(fb_regulate), .fault_oe(fault_oe), .fault_out(fault_out),
      .channel_used(channel_used), .active(active));
   ledseq_led_model model (.fitted(fitted), .broken(broken), .shorted(shorted),
      .channel_gate_drive(channel_gate_drive), .fault_oe(fault_oe), .fault_out(fault_out),
      .sense_below_ref(sense_below_ref), .open_string_protection(open_string_protection),
      .short_string_protection(short_string_protection), .fault_line(fault_line));
   // Clock and run limit
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   // Start-up through check, soft-start and blanking with faults held off
   task automatic t_start(input logic [3:0] m);
      fitted = m;
      shorted = 1'b1;
      enable_dim = 1'b1;
      n = 0;
      while (fb_hold_fixed !== 1'b1 && n < 4) begin tick(1); n++; end
      chk("active", active, 8'h01);
      tick(RC - 2);
      chk("gates in check", channel_gate_drive, 8'h00);
      tick(3);
      chk("used mask", channel_used, m);
      chk("gates after check", channel_gate_drive, m);
      fitted = ~m;
      n = 0;
      while (fb_hold_fixed === 1'b1 && n < 100) begin tick(1); n++; end
      chk("fixed feedback cycles", RC + 1 + n, RC + SC);
      chk("regulation", fb_regulate, 8'h01);
      chk("gates hold mask", channel_gate_drive, m);
      // Strings back in place for the protection tests
      fitted = m;
      tick(BC - 3);
      chk("fault in blanking", fault_oe, 8'h00);
      shorted = 1'b0;
      tick(6);
      chk("no fault after blanking", fault_oe, 8'h00);
   endtask
   // Short dimming gap gates currents without restart
   task automatic t_dim(input logic [3:0] m);
      enable_dim = 1'b0;
      tick(3);
      chk("gates in gap", channel_gate_drive, 8'h00);
      chk("still regulating", fb_regulate, 8'h01);
      enable_dim = 1'b1;
      tick(3);
      chk("gates after gap", channel_gate_drive, m);
      chk("no check rerun", fb_hold_fixed, 8'h00);
   endtask
   // Protection event: gates off and fault line pulled low
   task automatic t_fault();
      tick(4);
      chk("gates off", channel_gate_drive, 8'h00);
      chk("fault line", fault_line, 8'h00);
   endtask
   initial begin
      rst_b = 1'b0;
      enable_dim = 1'b0;
      supply_ok = 1'b0;
      shorted = 1'b0;
      fitted = 4'h0;
      broken = 4'h0;
      tick(8);
      rst_b = 1'b1;
      enable_dim = 1'b1;
      tick(4);
      chk("no supply", active, 8'h00);
      enable_dim = 1'b0;
      supply_ok = 1'b1;
      tick(4);
      chk("no enable", active, 8'h00);
      t_start(4'hA);
      t_dim(4'hA);
      broken = 4'h6;
      t_fault();
      broken = 4'h0;
      enable_dim = 1'b0;
      tick(DC - 2);
      chk("active in delay", active, 8'h01);
      tick(4);
      chk("shut down", active, 8'h00);
      t_start(4'h7);
      shorted = 1'b1;
      t_fault();
      supply_ok = 1'b0;
      tick(3);
      chk("lockout", active, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
